// ### shared/mcc_map.svh
/*
 * Offsets, field positions, reset values and frame counts of the
 * monitor channel control block.
 * Assumes it is included by bare name wherever a number is needed.
 */
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH

// address byte fields
`define MCC_ADDR_PD_BIT 7
`define MCC_ADDR_IDX_HI 6
`define MCC_ADDR_IDX_LO 3
`define MCC_ADDR_READ_BIT 2
`define MCC_ADDR_DATA_BIT 1

// chip select byte field
`define MCC_CS_HI 7
`define MCC_CS_LO 4

// register indices
`define MCC_IDX_FORMAT 4'h0
`define MCC_IDX_RXDATA 4'h2
`define MCC_IDX_TXINJ 4'h3
`define MCC_IDX_TEST 4'hA
`define MCC_IDX_LAST 4'hA

// reset values
`define MCC_CFG_RESET 8'h00

// interface format register fields
`define MCC_FMT_BCLK_HI 7
`define MCC_FMT_BCLK_LO 6
`define MCC_FMT_LAW 5
`define MCC_FMT_INV 4
`define MCC_FMT_TIMING 3
`define MCC_FMT_SPACING 2
`define MCC_FMT_SLOT 1
`define MCC_FMT_LOOP 0

// bit clock codes and rates in kHz
`define MCC_BCLK_512 2'h0
`define MCC_BCLK_1536 2'h1
`define MCC_BCLK_2048 2'h2
`define MCC_BCLK_2560 2'h3
`define MCC_KHZ_512 12'h200
`define MCC_KHZ_1536 12'h600
`define MCC_KHZ_2048 12'h800
`define MCC_KHZ_2560 12'hA00

// frame counts
`define MCC_MIN_IDLE_FRAMES 2'h2
`define MCC_MIN_HOLD_FRAMES 2'h2

`endif

// ### shared/mcc_pkg.sv
/*
 * Types of the monitor channel control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mcc_pkg;

  typedef enum logic [2:0] {
    MCC_RX_IDLE,
    MCC_RX_WAIT_VAL,
    MCC_RX_ACKED,
    MCC_RX_NEXT,
    MCC_RX_PREACK,
    MCC_RX_IGNORE
  } mcc_rx_state_t;

  typedef enum logic [1:0] {
    MCC_TX_IDLE,
    MCC_TX_SEND,
    MCC_TX_PREACK
  } mcc_tx_state_t;

  typedef enum logic [1:0] {
    MCC_LAW_MU,
    MCC_LAW_A_INV,
    MCC_LAW_A_PLAIN
  } mcc_law_t;

endpackage

// ### rtl/mcc_monitor_ctrl.sv
/*
 * Monitor channel control of a voice codec on a four-wire frame bus:
 * byte exchange on the monitor channel, address byte decode, register
 * file and the receive data FIFO.
 * Assumes frame sync, bit strobe and bus bits arrive as pins that are
 * asynchronous to clk; the bit strobe pulses only in the monitor slot.
 */
`timescale 1ns/100ps

`include "mcc_map.svh"

module mcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
      if (pop)
        rd_ptr_reg <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
      count_reg <= count_next;
      in_ready <= count_next != (AW+1)'(DEPTH);
      out_valid <= count_next != '0;
    end
  end
endmodule

// How it works
// - a monitor byte counts only when captured identical in two frames
// - a message starts with the strobe going active with the first byte
// - start sending only after partner ack idle for two frames or more
// - first byte valid: ack goes active and stays active next frame
// - abort means ack active for a single frame only
// - first byte never aborted; mismatch or wrong chip address stays silent
// - strobe inactive one frame marks next byte; longer means message end
// - next byte only after pre-ack; each byte held two frames at least
// - later bytes: ack drops for pre-ack, then returns for acknowledgement
// - failed later byte: pre-ack then ack left inactive, requesting abort
// - aborted reply is dropped; device waits for a new read command
// - every received byte acknowledged or aborted, no holding off
// - bytes shift most significant bit first
// - strobe and ack active low, released to high impedance when idle
// - writes are address byte then data byte after the chip select
// - address bit 7 power down, bit 1 data follows, bit 2 read-back
// - bits 6..3 index 0..10; index 2 feeds receive path, 3 and 10 write-only
// - format bits 7:6 select bit clock 512k, 1536k, 2048k, 2560k
// - bit 5 clear mu-law; set: bit 4 picks A-law with or without inversion
// - bit 3 delayed or non-delayed timing; bit 2 channel spacing
// - bit 1 seven-bit slot, bit 0 loop-back; all fields reset cleared
// - chip select upper nibble must match address pins, lower ignored
// - read-back answered by a single-byte message: register contents, or FIFO data for index 2
module mcc_monitor_ctrl
  import mcc_pkg::*;
#(
  parameter int FIFO_WIDTH = 8,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // frame bus pins
  input wire logic frame_sync_pin,
  input wire logic mon_bit_strobe_pin,
  input wire logic mon_data_in_pin,
  input wire logic sender_strobe_in_pin,
  input wire logic receiver_ack_in_pin,
  input wire logic [3:0] chip_address_pins,
  // open-drain bus outputs, driven low while enable is high
  output logic mon_data_out,
  output logic mon_data_oe,
  output logic sender_strobe_out,
  output logic sender_strobe_oe,
  output logic receiver_ack_out,
  output logic receiver_ack_oe,
  // received voice bus data into the fifo
  input wire logic [FIFO_WIDTH-1:0] bus_rx_data,
  input wire logic bus_rx_valid,
  output logic bus_rx_ready,
  // configuration
  output logic power_down_flag,
  output logic [1:0] bit_clock_select,
  output logic [11:0] bit_clock_khz,
  output mcc_law_t law_mode,
  output logic timing_select,
  output logic channel_spacing,
  output logic slot_length,
  output logic loopback_select,
  output logic [7:0] channel_path_config,
  // receive path and transmit inject data
  output logic [7:0] receive_path_data,
  output logic receive_path_strobe,
  output logic [7:0] transmit_inject_data,
  output logic transmit_inject_strobe
);
  logic [2:0] fs_sync_reg;
  logic [2:0] bit_sync_reg;
  logic [1:0] dr_sync_reg;
  logic [1:0] e_sync_reg;
  logic [1:0] a_sync_reg;
  logic [3:0] addr_sync_a_reg;
  logic [3:0] addr_sync_reg;
  logic frame_tick;
  logic bit_edge;
  logic e_n;
  logic a_n;
  logic [7:0] rx_shift_reg;
  logic [7:0] prev_byte_reg;
  logic prev_e_n_reg;
  mcc_rx_state_t rx_state_reg;
  logic byte_good_reg;
  logic msg_start_reg;
  logic take_reg;
  logic [7:0] take_byte_reg;
  logic expect_data_reg;
  logic [3:0] wr_idx_reg;
  logic [7:0] cfg_reg [11];
  logic read_req_reg;
  logic [3:0] read_idx_reg;
  logic tx_pending_reg;
  logic [7:0] tx_byte_reg;
  mcc_tx_state_t tx_state_reg;
  logic [7:0] tx_shift_reg;
  logic [1:0] tx_frames_reg;
  logic [1:0] ack_idle_reg;
  logic fifo_valid;
  logic fifo_pop;
  logic [FIFO_WIDTH-1:0] fifo_data;

  function automatic logic [11:0] bclk_khz(input logic [1:0] code);
    case (code)
      `MCC_BCLK_512: bclk_khz = `MCC_KHZ_512;
      `MCC_BCLK_1536: bclk_khz = `MCC_KHZ_1536;
      `MCC_BCLK_2048: bclk_khz = `MCC_KHZ_2048;
      default: bclk_khz = `MCC_KHZ_2560;
    endcase
  endfunction

  function automatic logic readable(input logic [3:0] idx);
    readable = idx <= `MCC_IDX_LAST && idx != `MCC_IDX_TXINJ
      && idx != `MCC_IDX_TEST;
  endfunction

  // pin synchronisers; first stages feed only second stages
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fs_sync_reg <= 3'h0;
      bit_sync_reg <= 3'h0;
      dr_sync_reg <= 2'h3;
      e_sync_reg <= 2'h3;
      a_sync_reg <= 2'h3;
      addr_sync_a_reg <= 4'h0;
      addr_sync_reg <= 4'h0;
    end
    else
    begin
      fs_sync_reg <= {fs_sync_reg[1:0], frame_sync_pin};
      bit_sync_reg <= {bit_sync_reg[1:0], mon_bit_strobe_pin};
      dr_sync_reg <= {dr_sync_reg[0], mon_data_in_pin};
      e_sync_reg <= {e_sync_reg[0], sender_strobe_in_pin};
      a_sync_reg <= {a_sync_reg[0], receiver_ack_in_pin};
      addr_sync_a_reg <= chip_address_pins;
      addr_sync_reg <= addr_sync_a_reg;
    end
  end

  // frame edge aligned with the strobe and ack samples
  assign frame_tick = fs_sync_reg[1] && !fs_sync_reg[2];
  assign bit_edge = bit_sync_reg[1] && !bit_sync_reg[2];
  assign e_n = e_sync_reg[1];
  assign a_n = a_sync_reg[1];

  // serial capture of the monitor byte
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_shift_reg <= 8'hFF;
      prev_byte_reg <= 8'hFF;
      prev_e_n_reg <= 1'b1;
    end
    else
    begin
      if (bit_edge)
        rx_shift_reg <= {rx_shift_reg[6:0], dr_sync_reg[1]};
      if (frame_tick)
      begin
        prev_byte_reg <= rx_shift_reg;
        prev_e_n_reg <= e_n;
      end
    end
  end

  // receiving side of the exchange, one step per frame
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_state_reg <= MCC_RX_IDLE;
      receiver_ack_oe <= 1'b0;
      byte_good_reg <= 1'b0;
      msg_start_reg <= 1'b0;
      take_reg <= 1'b0;
      take_byte_reg <= 8'h00;
    end
    else
    begin
      msg_start_reg <= 1'b0;
      take_reg <= 1'b0;
      if (frame_tick)
      begin
        case (rx_state_reg)
          MCC_RX_IDLE:
          begin
            receiver_ack_oe <= 1'b0;
            if (!e_n)
              rx_state_reg <= MCC_RX_WAIT_VAL;
          end
          MCC_RX_WAIT_VAL:
          begin
            if (e_n)
              rx_state_reg <= MCC_RX_IDLE;
            else if (rx_shift_reg == prev_byte_reg)
            begin
              if (rx_shift_reg[`MCC_CS_HI:`MCC_CS_LO] == addr_sync_reg)
              begin
                receiver_ack_oe <= 1'b1;
                msg_start_reg <= 1'b1;
                rx_state_reg <= MCC_RX_ACKED;
              end
              else
                rx_state_reg <= MCC_RX_IGNORE;
            end
          end
          MCC_RX_ACKED:
          begin
            if (e_n)
              rx_state_reg <= MCC_RX_NEXT;
          end
          MCC_RX_NEXT:
          begin
            receiver_ack_oe <= 1'b0;
            byte_good_reg <= rx_shift_reg == prev_byte_reg;
            if (e_n)
              rx_state_reg <= MCC_RX_IDLE;
            else
              rx_state_reg <= MCC_RX_PREACK;
          end
          MCC_RX_PREACK:
          begin
            if (byte_good_reg)
            begin
              receiver_ack_oe <= 1'b1;
              take_reg <= 1'b1;
              take_byte_reg <= prev_byte_reg;
              rx_state_reg <= MCC_RX_ACKED;
            end
            else
              rx_state_reg <= MCC_RX_IDLE;
          end
          MCC_RX_IGNORE:
          begin
            if (e_n && prev_e_n_reg)
              rx_state_reg <= MCC_RX_IDLE;
          end
          default:
            rx_state_reg <= MCC_RX_IDLE;
        endcase
      end
    end
  end

  // address and data byte decode, register writes
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      expect_data_reg <= 1'b0;
      wr_idx_reg <= 4'h0;
      power_down_flag <= 1'b0;
      read_req_reg <= 1'b0;
      read_idx_reg <= 4'h0;
      receive_path_strobe <= 1'b0;
      transmit_inject_strobe <= 1'b0;
      for (int i = 0; i < 11; i++)
        cfg_reg[i] <= `MCC_CFG_RESET;
    end
    else
    begin
      read_req_reg <= 1'b0;
      receive_path_strobe <= 1'b0;
      transmit_inject_strobe <= 1'b0;
      if (msg_start_reg)
        expect_data_reg <= 1'b0;
      else if (take_reg && !expect_data_reg)
      begin
        power_down_flag <= take_byte_reg[`MCC_ADDR_PD_BIT];
        if (take_byte_reg[`MCC_ADDR_DATA_BIT])
        begin
          if (take_byte_reg[`MCC_ADDR_READ_BIT])
          begin
            read_req_reg <= 1'b1;
            read_idx_reg <=
              take_byte_reg[`MCC_ADDR_IDX_HI:`MCC_ADDR_IDX_LO];
          end
          else
          begin
            wr_idx_reg <= take_byte_reg[`MCC_ADDR_IDX_HI:`MCC_ADDR_IDX_LO];
            expect_data_reg <= 1'b1;
          end
        end
      end
      else if (take_reg)
      begin
        expect_data_reg <= 1'b0;
        if (wr_idx_reg <= `MCC_IDX_LAST)
          cfg_reg[wr_idx_reg] <= take_byte_reg;
        receive_path_strobe <= wr_idx_reg == `MCC_IDX_RXDATA;
        transmit_inject_strobe <= wr_idx_reg == `MCC_IDX_TXINJ;
      end
    end
  end

  // configuration outputs held in flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_clock_select <= `MCC_BCLK_512;
      bit_clock_khz <= `MCC_KHZ_512;
      law_mode <= MCC_LAW_MU;
      timing_select <= 1'b0;
      channel_spacing <= 1'b0;
      slot_length <= 1'b0;
      loopback_select <= 1'b0;
      channel_path_config <= `MCC_CFG_RESET;
      receive_path_data <= `MCC_CFG_RESET;
      transmit_inject_data <= `MCC_CFG_RESET;
    end
    else
    begin
      bit_clock_select <=
        cfg_reg[`MCC_IDX_FORMAT][`MCC_FMT_BCLK_HI:`MCC_FMT_BCLK_LO];
      bit_clock_khz <= bclk_khz(
        cfg_reg[`MCC_IDX_FORMAT][`MCC_FMT_BCLK_HI:`MCC_FMT_BCLK_LO]);
      if (!cfg_reg[`MCC_IDX_FORMAT][`MCC_FMT_LAW])
        law_mode <= MCC_LAW_MU;
      else if (!cfg_reg[`MCC_IDX_FORMAT][`MCC_FMT_INV])
        law_mode <= MCC_LAW_A_INV;
      else
        law_mode <= MCC_LAW_A_PLAIN;
      timing_select <= cfg_reg[`MCC_IDX_FORMAT][`MCC_FMT_TIMING];
      channel_spacing <= cfg_reg[`MCC_IDX_FORMAT][`MCC_FMT_SPACING];
      slot_length <= cfg_reg[`MCC_IDX_FORMAT][`MCC_FMT_SLOT];
      loopback_select <= cfg_reg[`MCC_IDX_FORMAT][`MCC_FMT_LOOP];
      channel_path_config <= cfg_reg[1];
      receive_path_data <= cfg_reg[`MCC_IDX_RXDATA];
      transmit_inject_data <= cfg_reg[`MCC_IDX_TXINJ];
    end
  end

  // read-back of index 2 drains received bus data
  assign fifo_pop = read_req_reg && read_idx_reg == `MCC_IDX_RXDATA;

  mcc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(bus_rx_valid),
    .in_ready(bus_rx_ready),
    .in_data(bus_rx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // partner ack idle frames, saturating
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ack_idle_reg <= 2'h0;
    else if (frame_tick)
    begin
      if (!a_n)
        ack_idle_reg <= 2'h0;
      else if (ack_idle_reg != 2'h3)
        ack_idle_reg <= ack_idle_reg + 2'h1;
    end
  end

  // sending side: single-byte reply messages
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_state_reg <= MCC_TX_IDLE;
      tx_pending_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      tx_shift_reg <= 8'hFF;
      tx_frames_reg <= 2'h0;
      sender_strobe_oe <= 1'b0;
      mon_data_oe <= 1'b0;
    end
    else
    begin
      if (frame_tick)
      begin
        case (tx_state_reg)
          MCC_TX_IDLE:
          begin
            if (tx_pending_reg && ack_idle_reg >= `MCC_MIN_IDLE_FRAMES)
            begin
              tx_pending_reg <= 1'b0;
              sender_strobe_oe <= 1'b1;
              tx_shift_reg <= tx_byte_reg;
              tx_frames_reg <= 2'h1;
              tx_state_reg <= MCC_TX_SEND;
            end
          end
          MCC_TX_SEND:
          begin
            tx_shift_reg <= tx_byte_reg;
            if (tx_frames_reg != 2'h3)
              tx_frames_reg <= tx_frames_reg + 2'h1;
            if (!a_n && tx_frames_reg >= `MCC_MIN_HOLD_FRAMES)
              tx_state_reg <= MCC_TX_PREACK;
          end
          MCC_TX_PREACK:
          begin
            sender_strobe_oe <= 1'b0;
            tx_state_reg <= MCC_TX_IDLE;
          end
          default:
            tx_state_reg <= MCC_TX_IDLE;
        endcase
        mon_data_oe <= 1'b0;
      end
      else if (bit_edge && tx_state_reg != MCC_TX_IDLE)
      begin
        mon_data_oe <= !tx_shift_reg[7];
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
      end
      if (read_req_reg && readable(read_idx_reg))
      begin
        tx_pending_reg <= 1'b1;
        tx_byte_reg <= fifo_pop ? (fifo_valid ? fifo_data : 8'h00)
          : cfg_reg[read_idx_reg];
      end
    end
  end

  // open-drain lines only ever pull low
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mon_data_out <= 1'b0;
      sender_strobe_out <= 1'b0;
      receiver_ack_out <= 1'b0;
    end
    else
    begin
      mon_data_out <= 1'b0;
      sender_strobe_out <= 1'b0;
      receiver_ack_out <= 1'b0;
    end
  end

  a_first_valid: assert property (@(posedge clk) disable iff (!rst_b)
    frame_tick && rx_state_reg == MCC_RX_WAIT_VAL && !e_n
    && rx_shift_reg == prev_byte_reg
    && rx_shift_reg[7:4] == addr_sync_reg |=> receiver_ack_oe ##1
    receiver_ack_oe)
    else $error("first byte not acknowledged");
  a_first_silent: assert property (@(posedge clk) disable iff (!rst_b)
    frame_tick && rx_state_reg == MCC_RX_WAIT_VAL
    && rx_shift_reg != prev_byte_reg |=> !receiver_ack_oe)
    else $error("first byte mismatch answered");
  a_pre_ack: assert property (@(posedge clk) disable iff (!rst_b)
    frame_tick && rx_state_reg == MCC_RX_NEXT |=> !receiver_ack_oe)
    else $error("pre-ack missing");
  a_abort_req: assert property (@(posedge clk) disable iff (!rst_b)
    frame_tick && rx_state_reg == MCC_RX_PREACK && !byte_good_reg
    |=> !receiver_ack_oe && rx_state_reg == MCC_RX_IDLE)
    else $error("abort request not left inactive");
  a_start_gap: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(sender_strobe_oe) |-> $past(ack_idle_reg) >= 2'h2)
    else $error("send started without idle ack");
  a_hold_two: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(sender_strobe_oe) |-> $past(tx_frames_reg) >= 2'h2)
    else $error("byte held under two frames");
  a_abort_stop: assert property (@(posedge clk) disable iff (!rst_b)
    frame_tick && tx_state_reg == MCC_TX_PREACK
    |=> !sender_strobe_oe && !tx_pending_reg || read_req_reg)
    else $error("aborted message continued");
  a_shift_msb: assert property (@(posedge clk) disable iff (!rst_b)
    bit_edge |=> rx_shift_reg == {$past(rx_shift_reg[6:0]),
    $past(dr_sync_reg[1])})
    else $error("serial shift order wrong");
  a_law_decode: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg_reg[0][5] |=> law_mode == MCC_LAW_MU)
    else $error("mu-law not selected");
endmodule

// ### verification/mcc_bus_ctrl_model.sv
/* Bus controller model: frame sync, monitor bit strobes and bits, E and A
   bits towards the device; samples the device's open-drain enables.
   Assumes a free-running clk; the test drives frames through frame(). */
`timescale 1ns/100ps
module mcc_bus_ctrl_model (
  // clock
  input wire logic clk,
  // pins towards the device
  output logic frame_sync_pin,
  output logic mon_bit_strobe_pin,
  output logic mon_data_in_pin,
  output logic sender_strobe_in_pin,
  output logic receiver_ack_in_pin,
  // device enables, high pulls the line low
  input wire logic mon_data_oe,
  input wire logic sender_strobe_oe,
  input wire logic receiver_ack_oe
);
  initial
  begin
    frame_sync_pin = 1'b0;
    mon_bit_strobe_pin = 1'b0;
    mon_data_in_pin = 1'b1;
    sender_strobe_in_pin = 1'b1;
    receiver_ack_in_pin = 1'b1;
  end
  // one frame: sync, then E, A and eight bits
  task automatic frame(input logic e_n, input logic a_n,
    input logic [7:0] b, output logic ack, output logic stb,
    output logic [7:0] d);
    @(negedge clk);
    frame_sync_pin = 1'b1;
    repeat (6) @(negedge clk);
    frame_sync_pin = 1'b0;
    sender_strobe_in_pin = e_n;
    receiver_ack_in_pin = a_n;
    for (int i = 7; i >= 0; i--)
    begin
      mon_data_in_pin = b[i];
      repeat (2) @(negedge clk);
      mon_bit_strobe_pin = 1'b1;
      repeat (4) @(negedge clk);
      mon_bit_strobe_pin = 1'b0;
      repeat (2) @(negedge clk);
      d[i] = ~mon_data_oe;
    end
    mon_data_in_pin = 1'b1;
    ack = receiver_ack_oe;
    stb = sender_strobe_oe;
  endtask
endmodule

// ### verification/mcc_monitor_ctrl_tb.sv
/* Self-checking bench of the monitor channel control block.
   Assumes the design files and the bus controller model are compiled. */
`timescale 1ns/100ps
`include "mcc_map.svh"
module mcc_monitor_ctrl_tb
  import mcc_pkg::*;
();
  localparam logic [7:0] CS = 8'h5C;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic a_pin = 1'b1;
  logic abort_mode = 1'b0;
  logic fs, bs, din, e_in, a_in, d_oe, s_oe, a_oe;
  logic rx_ready, pd, ts, cs_sp, sl, lb, rp_stb, ti_stb, ack, stb;
  logic d_out, s_out, a_out;
  logic [1:0] bcs;
  logic [11:0] khz;
  mcc_law_t law;
  mcc_law_t lw;
  logic [7:0] cpc, rp_data, ti_data, first, v, d;
  logic [11:0] khz_tab [4] = '{`MCC_KHZ_512, `MCC_KHZ_1536,
    `MCC_KHZ_2048, `MCC_KHZ_2560};
  logic [7:0] rq[$];
  int err_total = 0;
  int total_checks = 0;
  int scnt = 0;
  int rp_cnt = 0;
  int ti_cnt = 0;
  int n;

  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    if (rp_stb === 1'b1)
      rp_cnt++;
    if (ti_stb === 1'b1)
      ti_cnt++;
  end

  mcc_monitor_ctrl u_mcc_monitor_ctrl (
    .clk(clk), .rst_b(rst_b), .frame_sync_pin(fs),
    .mon_bit_strobe_pin(bs), .mon_data_in_pin(din),
    .sender_strobe_in_pin(e_in), .receiver_ack_in_pin(a_in),
    .chip_address_pins(4'h5), .mon_data_out(d_out), .mon_data_oe(d_oe),
    .sender_strobe_out(s_out), .sender_strobe_oe(s_oe),
    .receiver_ack_out(a_out), .receiver_ack_oe(a_oe),
    .bus_rx_data(rx_data), .bus_rx_valid(rx_valid),
    .bus_rx_ready(rx_ready), .power_down_flag(pd),
    .bit_clock_select(bcs), .bit_clock_khz(khz), .law_mode(law),
    .timing_select(ts), .channel_spacing(cs_sp), .slot_length(sl),
    .loopback_select(lb), .channel_path_config(cpc),
    .receive_path_data(rp_data), .receive_path_strobe(rp_stb),
    .transmit_inject_data(ti_data), .transmit_inject_strobe(ti_stb)
  );

  mcc_bus_ctrl_model u_mcc_bus_ctrl_model (
    .clk(clk), .frame_sync_pin(fs), .mon_bit_strobe_pin(bs),
    .mon_data_in_pin(din), .sender_strobe_in_pin(e_in),
    .receiver_ack_in_pin(a_in), .mon_data_oe(d_oe),
    .sender_strobe_oe(s_oe), .receiver_ack_oe(a_oe)
  );

  task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one frame; x is the expected ack, 2 for none; answers device replies
  task automatic fr(input logic e, input logic [7:0] b, input int x);
    u_mcc_bus_ctrl_model.frame(e, a_pin, b, ack, stb, d);
    if (x != 2)
      check_val({11'h000, ack}, 12'(x));
    if (stb === 1'b1)
      scnt++;
    else
      scnt = 0;
    if (scnt == 1)
      first = d;
    if (scnt == 2 && d === first)
      rq.push_back(d);
    a_pin = !(scnt >= 2 && !(abort_mode && scnt > 2));
  endtask

  // chip select, then the bytes of q, each held until pre-ack is seen;
  // byte bad changes after its first copy
  task automatic send_msg(input logic [7:0] q[$], input int bad = -1);
    logic [7:0] b;
    fr(1'b1, 8'hFF, 2);
    fr(1'b1, 8'hFF, 0);
    fr(1'b1, 8'hFF, 0);
    fr(1'b0, CS, 0);
    fr(1'b0, CS, 0);
    for (int j = 0; j <= q.size(); j++)
    begin
      b = (j < q.size()) ? q[j] : 8'hFF;
      fr(1'b1, b, 1);
      fr(j == q.size(), (j == bad) ? b ^ 8'h08 : b, 1);
      if (j < q.size())
        fr(1'b0, (j == bad) ? b ^ 8'h08 : b, 0);
      if (j == bad)
      begin
        fr(1'b1, 8'hFF, 0);
        fr(1'b1, 8'hFF, 0);
        return;
      end
    end
  endtask

  task automatic read_reg(input logic [7:0] a, input logic [7:0] exp,
    input int cnt);
    rq.delete();
    send_msg({a});
    repeat (8) fr(1'b1, 8'hFF, 2);
    check_val(12'(rq.size()), 12'(cnt));
    if (cnt > 0)
      check_val({4'h0, rq[0]}, {4'h0, exp});
  endtask

  task automatic complete_run();
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    check_val({3'h0, bcs, ts, cs_sp, sl, lb, pd, law}, 12'h000);
    check_val(khz, `MCC_KHZ_512);
    read_reg(8'h06, 8'h00, 1);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'(8'h55 * i);
      lw = v[5] ? (v[4] ? MCC_LAW_A_PLAIN : MCC_LAW_A_INV) : MCC_LAW_MU;
      send_msg({8'h02, v, 8'h0A, ~v});
      check_val(12'({bcs, ts, cs_sp, sl, lb}), 12'({v[7:6], v[3:0]}));
      check_val(khz, khz_tab[v[7:6]]);
      check_val({10'h000, lw}, {10'h000, law});
      check_val({4'h0, cpc}, {4'h0, ~v});
      read_reg(8'h06, v, 1);
    end
    send_msg({8'h80});
    check_val({11'h000, pd}, 12'h001);
    send_msg({8'h00});
    check_val({11'h000, pd}, 12'h000);
    for (int i = 0; i < 6; i++)
      fr(i > 3, (i > 3) ? 8'hFF : 8'h3C, 0);
    fr(1'b0, CS, 0);
    fr(1'b0, CS ^ 8'h01, 0);
    fr(1'b0, CS ^ 8'h01, 0);
    fr(1'b1, 8'hFF, 1);
    send_msg({8'h0A, 8'h5A}, 1);
    check_val({4'h0, cpc}, 12'h000);
    send_msg({8'h12, 8'h3C, 8'h1A, 8'hC3});
    check_val({4'h0, rp_data}, 12'h03C);
    check_val({4'h0, ti_data}, 12'h0C3);
    check_val(12'(rp_cnt * 16 + ti_cnt), 12'h011);
    read_reg(8'h1E, 8'h00, 0);
    read_reg(8'h56, 8'h00, 0);
    n = 0;
    for (int i = 0; i < 12; i++)
    begin
      @(negedge clk);
      rx_valid = (rx_ready === 1'b1);
      rx_data = 8'(8'hA0 + n);
      n += int'(rx_valid);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    check_val(12'(n), 12'h008);
    for (int i = 0; i < 9; i++)
      read_reg(8'h16, (i < 8) ? 8'(8'hA0 + i) : 8'h00, 1);
    abort_mode = 1'b1;
    read_reg(8'h06, 8'hFF, 1);
    check_val({9'h000, d_out, s_out, a_out}, 12'h000);
    complete_run();
  end
endmodule
